// file: adc_config_and_sequencer.sv
// converter registers and acquisition/conversion sequencer, apb slave
// assumes comparator and sample switch outside; strap valid at reset release
//
// Decided for this implementation: the APB slave port and the placing of the registers.
module adc_config_and_sequencer
  import adc_ctrl_pkg::*;
#(
  parameter int rc_cycles = rc_period_cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic portb_analog_default,
  input wire logic sleep_mode,
  input wire logic comp_above,
  output logic hold_sample,
  output logic [9:0] dac_trial,
  output logic [3:0] channel_select,
  output logic [10:0] analog_input_en,
  output logic neg_ref_select,
  output logic pos_ref_select,
  output logic converter_on,
  output logic conv_done_irq_flag
);
  logic [3:0] chan_reg;
  logic on_reg;
  logic go_reg;
  logic neg_ref_reg;
  logic pos_ref_reg;
  logic [3:0] port_cfg_reg;
  logic justify_reg;
  logic [2:0] acq_reg;
  logic [2:0] clk_sel_reg;
  logic flag_reg;
  logic strap_taken_reg;
  logic [9:0] result_reg;
  logic [9:0] sar_reg;
  logic [4:0] count_reg;
  logic [1:0] start_reg;
  seq_state_t state_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;
  logic sleep_meta_reg;
  logic sleep_sync_reg;

  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_ref;
  logic hit_fmt;
  logic hit_rh;
  logic hit_rl;
  logic hit_stat;
  logic mapped;
  logic tick;
  logic rc_sel;
  logic clk_run;
  logic go_set;
  logic go_clear;
  logic conv_end;
  logic [4:0] acq_periods;
  logic [15:0] res_word;
  logic [9:0] sar_bit;
  logic [9:0] sar_keep;
  logic [7:0] cur_high;
  logic [7:0] cur_low;
  logic chan_bad;

  function automatic logic [4:0] acq_len(input logic [2:0] code);
    unique case (code)
      3'h0: acq_len = 5'd0;
      3'h1: acq_len = 5'd2;
      3'h2: acq_len = 5'd4;
      3'h3: acq_len = 5'd6;
      3'h4: acq_len = 5'd8;
      3'h5: acq_len = 5'd12;
      3'h6: acq_len = 5'd16;
      3'h7: acq_len = 5'd20;
    endcase
  endfunction : acq_len

  // apb decode, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign hit_ctrl = (paddr == ctrl_off);
  assign hit_ref = (paddr == ref_port_off);
  assign hit_fmt = (paddr == fmt_time_off);
  assign hit_rh = (paddr == result_high_off);
  assign hit_rl = (paddr == result_low_off);
  assign hit_stat = (paddr == status_off);
  assign mapped = hit_ctrl | hit_ref | hit_fmt | hit_rh | hit_rl | hit_stat;
  assign pslverr = psel && penable && !mapped;

  assign acq_periods = acq_len(acq_reg);
  assign go_set = wr_en && hit_ctrl && pwdata[ctrl_go_bit] && on_reg &&
                  !go_reg;
  // clearing go/done aborts; only a conversion ending in that same cycle still writes the result
  assign go_clear = wr_en && hit_ctrl && !pwdata[ctrl_go_bit];
  // bit clock only ticks after the start delay: four pclk cycles on rc, one otherwise
  assign clk_run = (state_reg != st_sample) &&
                   (state_reg != st_start_wait);
  // fixed dividers stop in sleep; only the rc source keeps going
  assign conv_end = (state_reg == st_convert) && tick &&
                    (count_reg == 5'(conv_periods - 1));
  assign chan_bad = (chan_reg >= chan_count);
  assign sar_bit = 10'h200 >> count_reg[3:0];
  assign sar_keep = comp_above ? sar_reg : (sar_reg & ~sar_bit);

  // justified result placement
  assign res_word = justify_reg ? {6'h00, result_reg} :
                                  {result_reg, 6'h00};
  assign cur_high = res_word[15:8];
  assign cur_low = res_word[7:0];

  adc_bit_clock #(
    .rc_cycles(rc_cycles)
  ) u_bit_clock (
    .pclk(pclk),
    .presetn(presetn),
    .run(clk_run && (rc_sel || !sleep_sync_reg)),
    .clk_sel(clk_sel_reg),
    .tick(tick),
    .rc_selected(rc_sel)
  );

  // registers, reset restores and module is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_reg <= 4'h0;
      on_reg <= 1'b0;
      neg_ref_reg <= 1'b0;
      pos_ref_reg <= 1'b0;
      justify_reg <= 1'b0;
      acq_reg <= 3'h0;
      clk_sel_reg <= 3'h0;
    end else if (wr_en && hit_ctrl) begin
      chan_reg <= pwdata[ctrl_chan_lsb +: 4];
      on_reg <= pwdata[ctrl_on_bit];
    end else if (wr_en && hit_ref) begin
      neg_ref_reg <= pwdata[neg_ref_bit];
      pos_ref_reg <= pwdata[pos_ref_bit];
    end else if (wr_en && hit_fmt) begin
      justify_reg <= pwdata[justify_bit];
      acq_reg <= pwdata[acq_lsb +: 3];
      clk_sel_reg <= pwdata[2:0];
    end
  end

  // pins cross into pclk through two flops; no reset, so the strap
  // has long settled by the time reset lets go
  always_ff @(posedge pclk) begin
    strap_meta_reg <= portb_analog_default;
    strap_sync_reg <= strap_meta_reg;
    sleep_meta_reg <= sleep_mode;
    sleep_sync_reg <= sleep_meta_reg;
  end

  // strap sampled by a clocked process after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_cfg_reg <= 4'h0;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      port_cfg_reg <= strap_sync_reg ? port_cfg_strap_one :
                                             port_cfg_strap_zero;
    end else if (wr_en && hit_ref) begin
      port_cfg_reg <= pwdata[3:0];
    end
  end

  // done flag: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (conv_end) begin
      flag_reg <= 1'b1;
    end else if (wr_en && hit_stat && pwdata[0]) begin
      flag_reg <= 1'b0;
    end
  end

  // result pair has no reset so power-up contents stay unknown
  always_ff @(posedge pclk) begin
    if (conv_end) begin
      result_reg <= chan_bad ? 10'h3FF : sar_keep;
    end else if (wr_en && hit_rh) begin
      result_reg <= justify_reg ? {pwdata[1:0], result_reg[7:0]} :
                                  {pwdata[7:0], result_reg[1:0]};
    end else if (wr_en && hit_rl) begin
      result_reg <= justify_reg ? {result_reg[9:8], pwdata[7:0]} :
                                  {result_reg[9:2], pwdata[7:6]};
    end
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_sample;
      go_reg <= 1'b0;
      count_reg <= 5'd0;
      start_reg <= 2'd0;
      sar_reg <= 10'h000;
    end else if (!on_reg || (go_clear && go_reg)) begin
      // off: no settle wait, it would never end while held off
      state_reg <= (!on_reg || state_reg == st_sample) ? st_sample :
                                                         st_settle;
      go_reg <= 1'b0;
      count_reg <= 5'd0;
    end else begin
      unique case (state_reg)
        st_sample: begin
          if (go_set) begin
            go_reg <= 1'b1;
            start_reg <= 2'd0;
            count_reg <= 5'd0;
            state_reg <= st_start_wait;
          end
        end
        st_start_wait: begin
          // on rc one instruction cycle so a sleep can be entered first, one pclk otherwise
          start_reg <= start_reg + 2'd1;
          if (!rc_sel || start_reg == 2'(instr_cycle_clocks - 1)) begin
            state_reg <= (acq_periods == 5'd0) ? st_convert :
                                                 st_acquire;
            sar_reg <= 10'h200;
          end
        end
        st_acquire: begin
          if (tick) begin
            count_reg <= count_reg + 5'd1;
            if (count_reg == acq_periods - 5'd1) begin
              count_reg <= 5'd0;
              state_reg <= st_convert;
            end
          end
        end
        st_convert: begin
          if (tick) begin
            count_reg <= count_reg + 5'd1;
            if (count_reg < 5'd10) begin
              sar_reg <= sar_keep | (sar_bit >> 1);
            end
            if (conv_end) begin
              go_reg <= 1'b0;
              count_reg <= 5'd0;
              state_reg <= st_settle;
            end
          end
        end
        st_settle: begin
          if (tick) begin
            count_reg <= count_reg + 5'd1;
            if (count_reg == 5'(post_conv_wait - 1)) begin
              count_reg <= 5'd0;
              state_reg <= st_sample;
            end
          end
        end
      endcase
    end
  end

  // read mux, upper bits zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= hit_ctrl ? {26'h0, chan_reg, go_reg, on_reg} :
                hit_ref ? {26'h0, neg_ref_reg, pos_ref_reg,
                           port_cfg_reg} :
                hit_fmt ? {24'h0, justify_reg, 1'b0, acq_reg,
                           clk_sel_reg} :
                hit_rh ? {24'h0, cur_high} :
                hit_rl ? {24'h0, cur_low} :
                hit_stat ? {31'h0, flag_reg} : 32'h00000000;
    end
  end

  // analog side controls
  assign hold_sample = (state_reg == st_convert) ||
                       (state_reg == st_settle);
  assign dac_trial = sar_reg;
  assign channel_select = chan_reg;
  assign neg_ref_select = neg_ref_reg;
  assign pos_ref_select = pos_ref_reg;
  assign converter_on = on_reg;
  assign conv_done_irq_flag = flag_reg;

  // input k is analog while code <= 4 + (10 - k)
  for (genvar k = 0; k < 11; k++) begin : g_port
    assign analog_input_en[k] = (port_cfg_reg <=
      port_all_analog_max + 4'(10 - k));
  end
endmodule : adc_config_and_sequencer

// file: adc_ctrl_pkg.sv
// constants, register map and types for the converter control block
// assumes an apb slave at a 100 MHz pclk; analog side is outside
package adc_ctrl_pkg;
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] ref_port_off = 12'h004;
  localparam logic [11:0] fmt_time_off = 12'h008;
  localparam logic [11:0] result_high_off = 12'h00C;
  localparam logic [11:0] result_low_off = 12'h010;
  localparam logic [11:0] status_off = 12'h014;
  // register field positions and converter constants
  localparam int ctrl_on_bit = 0;
  localparam int ctrl_go_bit = 1;
  localparam int ctrl_chan_lsb = 2;
  localparam int neg_ref_bit = 5;
  localparam int pos_ref_bit = 4;
  localparam int justify_bit = 7;
  localparam int acq_lsb = 3;
  localparam logic [3:0] port_cfg_strap_one = 4'h0;
  localparam logic [3:0] port_cfg_strap_zero = 4'h7;
  localparam logic [3:0] port_all_analog_max = 4'h4;
  localparam logic [3:0] chan_count = 4'hB;
  localparam int conv_periods = 11;
  localparam int post_conv_wait = 2;
  // one instruction cycle is four oscillator clocks
  localparam int instr_cycle_clocks = 4;
  localparam int rc_period_ns = 2000;
  localparam int clk_period_ns = 10;
  localparam int rc_period_cycles = rc_period_ns / clk_period_ns;
  typedef enum logic [2:0] {
    st_sample, st_start_wait, st_acquire, st_convert, st_settle
  } seq_state_t;
endpackage : adc_ctrl_pkg

// file: adc_bit_clock.sv
// bit-period enable generator for the converter
// assumes one pclk domain; rc source is a divider of pclk here
module adc_bit_clock
  import adc_ctrl_pkg::*;
#(
  parameter int rc_cycles = rc_period_cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  output logic tick,
  output logic rc_selected
);
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [7:0] limit;

  // fixed dividers then internal rc
  assign rc_selected = (clk_sel[1:0] == 2'b11);
  assign limit = rc_selected ? 8'(rc_cycles - 1) :
                 (clk_sel == 3'b000) ? 8'h01 :
                 (clk_sel == 3'b001) ? 8'h07 :
                 (clk_sel == 3'b010) ? 8'h1F :
                 (clk_sel == 3'b100) ? 8'h03 :
                 (clk_sel == 3'b101) ? 8'h0F : 8'h3F;
  assign tick = run && (div_reg >= limit);
  assign div_next = !run ? 8'h00 : (tick ? 8'h00 : div_reg + 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_next;
    end
  end
endmodule : adc_bit_clock

// file: adc_ctrl_assertions.sv
// port assertions for the converter control block
// assumes one pclk domain and the package register offsets
module adc_ctrl_assertions
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hold_sample,
  input wire logic [10:0] analog_input_en,
  input wire logic neg_ref_select,
  input wire logic pos_ref_select,
  input wire logic converter_on,
  input wire logic conv_done_irq_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr_ref = acc && pwrite && paddr == ref_port_off;
  wire [3:0] code = pwdata[3:0];
  wire [10:0] en_exp = (code <= port_all_analog_max) ? 11'h7FF
    : 11'h7FF >> (code - 4'h4);
  zero_wait_a: assert property (psel |-> pready)
    else $error("wait state inserted");
  unmapped_err_a: assert property (acc && paddr > status_off |-> pslverr)
    else $error("unmapped access not flagged");
  port_map_a: assert property (
    wr_ref |=> analog_input_en == $past(en_exp))
    else $error("analog enables wrong");
  ref_select_a: assert property (wr_ref |=>
    {neg_ref_select, pos_ref_select} == $past(pwdata[5:4]))
    else $error("reference selects wrong");
  reset_off_a: assert property (
    $rose(presetn) |-> !converter_on && !hold_sample)
    else $error("module active after reset");
  done_settle_a: assert property (
    $rose(conv_done_irq_flag) |-> hold_sample[*4])
    else $error("sampling resumed too soon");
  done_on_a: assert property (
    $rose(conv_done_irq_flag) |-> converter_on)
    else $error("done flag while off");
  hold_min_a: assert property (
    $rose(hold_sample) |-> hold_sample[*8])
    else $error("conversion too short");
  hold_max_a: assert property (
    $rose(hold_sample) |-> ##[1:900] !hold_sample)
    else $error("conversion never ends");
endmodule : adc_ctrl_assertions

bind adc_config_and_sequencer adc_ctrl_assertions i_adc_ctrl_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .hold_sample, .analog_input_en, .neg_ref_select,
  .pos_ref_select, .converter_on, .conv_done_irq_flag
);

// file: testbench.sv
// self-checking bench for the converter control block over apb
// assumes rc source shortened to 4 pclk; comparator modelled inline
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic portb_analog_default, sleep_mode, hold_sample, hold_q;
  logic neg_ref_select, pos_ref_select, converter_on, conv_done_irq_flag;
  logic [9:0] dac_trial, target;
  logic [3:0] channel_select;
  logic [10:0] analog_input_en;
  int n_errors, compares, cyc, t_go, t_rise, t_fall, base;
  int acqp[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int divs[8] = '{2, 8, 32, 4, 4, 16, 64, 4};
  // ideal comparator: input at target level
  wire comp_above = target >= dac_trial;

  adc_config_and_sequencer #(.rc_cycles(4)) i_adc_config_and_sequencer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .portb_analog_default, .sleep_mode, .comp_above,
    .hold_sample, .dac_trial, .channel_select, .analog_input_en,
    .neg_ref_select, .pos_ref_select, .converter_on, .conv_done_irq_flag
  );

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    // non-blocking so every reader at this edge sees the same count
    cyc <= cyc + 1;
    if (hold_sample === 1'b1 && hold_q !== 1'b1) t_rise = cyc;
    if (hold_sample === 1'b0 && hold_q === 1'b1) t_fall = cyc;
    hold_q = hold_sample;
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end

  task complete_run;
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // apb transfer; holds the request until pready at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : xfer

  task result(input logic [7:0] hi, input logic [7:0] lo);
    xfer(0, result_high_off, 0);
    chk("result high", hi, rd);
    xfer(0, result_low_off, 0);
    chk("result low", lo, rd);
  endtask : result

  task conv(input logic [7:0] fmt, input logic [3:0] ch);
    xfer(1, fmt_time_off, fmt);
    xfer(1, ctrl_off, 1);
    xfer(1, ctrl_off, {ch, 2'b11});
    t_go = cyc;
    for (int i = 0; i < 2000 && t_fall <= t_go; i++) @(posedge pclk);
    xfer(0, ctrl_off, 0);
    chk("go cleared", {ch, 2'b01}, rd);
    chk("channel", ch, channel_select);
  endtask : conv

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {portb_analog_default, sleep_mode, hold_q} = 0;
    {n_errors, compares, cyc, t_rise, t_fall} = 0;
    target = 10'h2A5;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    xfer(0, ref_port_off, 0);
    chk("ref reset", 32'h7, rd);
    chk("enables reset", 11'h0FF, analog_input_en);
    xfer(0, 12'h040, 0);
    chk("unmapped read", 0, rd);
    chk("unmapped error", 1, err);
    for (int c = 0; c < 16; c++) begin
      xfer(1, ref_port_off, 32'hC0 | c[3:0] | (c[0] ? 32'h20 : 32'h10));
      xfer(0, ref_port_off, 0);
      chk("ref read", (c[0] ? 32'h20 : 32'h10) | c[3:0], rd);
      chk("enables", 11'h7FF >> (c < 5 ? 0 : c - 4), analog_input_en);
      chk("refs", {c[0], ~c[0]}, {neg_ref_select, pos_ref_select});
    end
    xfer(1, fmt_time_off, 32'hFF);
    xfer(0, fmt_time_off, 0);
    chk("fmt read", 32'hBF, rd);
    $display("register test done");
    conv(8'h80, 4'h0);
    base = t_rise - t_go;
    chk("hold length", 26, t_fall - t_rise);
    result(8'h02, 8'hA5);
    for (int a = 1; a < 8; a++) begin
      conv({2'b00, a[2:0], 3'b000}, a[3:0]);
      chk("acquire", acqp[a] * 2, t_rise - t_go - base);
    end
    result(8'hA9, 8'h40);
    chk("done flag", 1, conv_done_irq_flag);
    xfer(1, status_off, 1);
    chk("flag clear", 0, conv_done_irq_flag);
    $display("acquisition test done");
    for (int k = 0; k < 8; k++) begin
      conv({5'b10000, k[2:0]}, 4'h1);
      chk("bit period", 13 * divs[k], t_fall - t_rise);
      if (k[1:0] == 2'b11)
        chk("rc start", instr_cycle_clocks - 1, t_rise - t_go - base);
      else
        chk("fixed start", 0, t_rise - t_go - base);
    end
    conv(8'h80, 4'hC);
    result(8'h03, 8'hFF);
    $display("clock test done");
    sleep_mode <= 1;
    conv(8'h83, 4'h2);
    chk("sleep rc", 52, t_fall - t_rise);
    xfer(1, fmt_time_off, 32'h80);
    xfer(1, ctrl_off, 32'h3);
    repeat (100) @(posedge pclk);
    xfer(0, ctrl_off, 0);
    chk("sleep stall", 32'h3, rd);
    sleep_mode <= 0;
    xfer(1, ctrl_off, 32'h1);
    repeat (20) @(posedge pclk);
    result(8'h02, 8'hA5);
    $display("sleep test done");
    xfer(1, fmt_time_off, 32'h86);
    xfer(1, ctrl_off, 32'h3);
    repeat (50) @(posedge pclk);
    portb_analog_default <= 1;
    presetn <= 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    chk("off after reset", 0, {converter_on, hold_sample});
    xfer(0, ref_port_off, 0);
    chk("ref strap", 0, rd);
    xfer(1, fmt_time_off, 32'h80);
    result(8'h02, 8'hA5);
    $display("reset test done");
    complete_run();
  end
endmodule : testbench
